/* File: ctm_pkg.sv */
// Shared constants for the charge-time edge control block.
// Assumes a 32-bit AXI4-Lite register bus; registers are 16 bits wide.
package ctm_pkg;
    // Byte offsets of the registers.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_EDGE = 4'h4;
    localparam logic [3:0] OFS_DSCH = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hC;
    // Control register fields.
    localparam int B_UNIT_EN = 15;
    localparam int B_IDLE_STOP = 13;
    localparam int B_DELAY_GEN = 12;
    localparam int B_EDGE_GATE = 11;
    localparam int B_ORDER_EN = 10;
    localparam int B_SRC_GND = 9;
    localparam int B_TRIG_EN = 8;
    localparam int B_TRIM_LO = 2;
    localparam int B_RANGE_LO = 0;
    // Edge select register fields.
    localparam int B_E1_MODE = 15;
    localparam int B_E1_POL = 14;
    localparam int B_E1_SEL = 10;
    localparam int B_E2_FLAG = 9;
    localparam int B_E1_FLAG = 8;
    localparam int B_E2_MODE = 7;
    localparam int B_E2_POL = 6;
    localparam int B_E2_SEL = 2;
    localparam int B_HI_RANGE = 0;
    // Discharge register fields.
    localparam int B_RST_EN = 4;
    localparam int B_DSCH_SEL = 0;
    // Writable masks; unlisted bits read as zero.
    localparam logic [15:0] MASK_CTRL = 16'hBFFF;
    localparam logic [15:0] MASK_EDGE = 16'hFFFD;
    localparam logic [15:0] MASK_DSCH = 16'h0017;
    localparam logic [15:0] RST_REG = 16'h0000;
    // Discharge codes 000 and 101 are disabled.
    localparam logic [7:0] DSCH_VALID = 8'hDE;
    // High range: codes 1x are reserved.
    localparam logic [1:0] RANGE_HI_RSVD = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: ctm_edge_ctrl.sv */
// Charge-time edge control: edge gating, sequencing, current source
// switching and routing, with an AXI4-Lite register slave.
// Assumes one 200 MHz clock; pins and comparator outputs are asynchronous.
//
// Contract
// RULE_01: Enable bit turns whole unit on.
// RULE_02: Idle-stop bit halts unit during Idle.
// RULE_03: Delay select routes current to comparator.
// RULE_04: Edge gate passes or blocks edges.
// RULE_05: Order bit needs first edge first.
// RULE_06: Ground bit ties source output low.
// RULE_07: Trigger bit enables trigger output.
// RULE_08: Six-bit signed trim of current.
// RULE_09: Two-bit range selects current magnitude.
// RULE_10: Diode route only when flags match.
// RULE_11: Software sets request and channel 24.
// RULE_12: Software holds sample control for routing.
// RULE_13: Delay mode drives comparator two input B.
// RULE_14: Delay pulse when capacitor passes reference.
// RULE_15: Output pulse spans first to second edge.
// RULE_16: Edges from internal sources or pins.
// RULE_17: Flags set by hardware, software writable.
// RULE_18: Per edge sense mode and polarity.
// RULE_19: High range: code 01 gives 2.2 mA.
// RULE_20: Reset enable lets discharge clear edges.
// RULE_21: Conduct while first set, second clear.
// RULE_22: Disable or reset clears flags, source off.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ctm_edge_ctrl
    import ctm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic idleMode,
    input wire logic [12:0] externalEdgePin,
    input wire logic timerMatch,
    input wire logic outputCompareChannel,
    input wire logic [2:0] captureIrq,
    input wire logic periphClkTick,
    input wire logic [2:0] comparatorOut,
    input wire logic [7:0] dischargeSource,
    output logic sourceConduct,
    output logic sourceGround,
    output logic routeAdc,
    output logic routeComparator2InputB,
    output logic routeTempDiode,
    output logic [5:0] currentTrim,
    output logic [1:0] currentRange,
    output logic highRangeSelect,
    output logic rangeReserved,
    output logic measurePulse,
    output logic delayedPulseOut,
    output logic triggerOut
);
    ////////////////////////////////////////////////////////////////////
    // Helpers.
    // Picks one of sixteen sources and applies polarity (1 = positive).
    function automatic logic pickLevel(input logic [15:0] srcs,
        input logic [3:0] sel, input logic pol);
        pickLevel = srcs[sel] ~^ pol;
    endfunction
    // Merges a 16-bit write into a register under byte strobes and mask.
    function automatic logic [15:0] mergeWrite(input logic [15:0] old,
        input logic [31:0] data, input logic [3:0] strb,
        input logic [15:0] mask);
        logic [15:0] m;
        m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        mergeWrite = (old & ~m) | (data[15:0] & m);
    endfunction
    ////////////////////////////////////////////////////////////////////
    // Registers and state.
    logic [15:0] ctrl_q; // Control register.
    logic [15:0] edgeSel_q; // Edge select register, flags held apart.
    logic [15:0] dsch_q; // Discharge register.
    logic flag1_q, flag2_q; // First and second edge status.
    logic lvl1_q, lvl2_q; // Previous polarity-adjusted levels.
    logic [12:0] pinMeta_q, pinSync_q; // Pin synchroniser stages.
    logic [2:0] cmpMeta_q, cmpSync_q; // Comparator synchroniser stages.
    logic awHeld_q, wHeld_q; // Write address and data captured.
    logic [3:0] awAddr_q; // Captured write address.
    logic [31:0] wData_q; // Captured write data.
    logic [3:0] wStrb_q; // Captured write strobes.
    ////////////////////////////////////////////////////////////////////
    // Bus handshake terms.
    logic awTake, wTake, doWrite, awHeld_d, wHeld_d, arTake, rValid_d;
    assign awTake = s_axi_awvalid & s_axi_awready;
    assign wTake = s_axi_wvalid & s_axi_wready;
    // A write lands only once both halves are in and no answer waits.
    assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
    assign awHeld_d = (awHeld_q | awTake) & ~doWrite;
    assign wHeld_d = (wHeld_q | wTake) & ~doWrite;
    assign arTake = s_axi_arvalid & s_axi_arready;
    assign rValid_d = arTake | (s_axi_rvalid & ~s_axi_rready);
    logic wrCtrl, wrEdge, wrDsch, wrMapped;
    assign wrCtrl = doWrite & (awAddr_q == OFS_CTRL);
    assign wrEdge = doWrite & (awAddr_q == OFS_EDGE);
    assign wrDsch = doWrite & (awAddr_q == OFS_DSCH);
    assign wrMapped = wrCtrl | wrEdge | wrDsch | (awAddr_q == OFS_STAT);
    ////////////////////////////////////////////////////////////////////
    // Control decode.
    logic unitRun, edgesPass, ground, delayMode;
    // The unit runs when enabled and not parked by Idle.
    assign unitRun = ctrl_q[B_UNIT_EN] //RULE_01
        & ~(ctrl_q[B_IDLE_STOP] & idleMode); //RULE_02
    assign edgesPass = unitRun & ctrl_q[B_EDGE_GATE]; //RULE_04
    assign ground = ctrl_q[B_SRC_GND];
    assign delayMode = ctrl_q[B_DELAY_GEN];
    ////////////////////////////////////////////////////////////////////
    // Edge sources and detection.
    logic [15:0] src1, src2;
    // Source tables per channel; pin index 0 is external pin 1.
    assign src1 = {cmpSync_q, captureIrq, pinSync_q[7:3], //RULE_16
                   pinSync_q[2], pinSync_q[0], pinSync_q[1],
                   outputCompareChannel, timerMatch};
    assign src2 = {cmpSync_q, periphClkTick, captureIrq, //RULE_16
                   pinSync_q[12:8], pinSync_q[0], pinSync_q[1],
                   outputCompareChannel, timerMatch};
    logic lvl1, lvl2, ev1, ev2;
    assign lvl1 = pickLevel(src1, edgeSel_q[B_E1_SEL +: 4],
                            edgeSel_q[B_E1_POL]); //RULE_18
    assign lvl2 = pickLevel(src2, edgeSel_q[B_E2_SEL +: 4],
                            edgeSel_q[B_E2_POL]); //RULE_18
    // Edge mode wants a fresh transition; level mode takes the level.
    assign ev1 = edgesPass & (edgeSel_q[B_E1_MODE] ?
                 (lvl1 & ~lvl1_q) : lvl1); //RULE_18
    // With ordering on, a second edge needs the first one already seen.
    assign ev2 = edgesPass & (edgeSel_q[B_E2_MODE] ?
                 (lvl2 & ~lvl2_q) : lvl2)
                 & (~ctrl_q[B_ORDER_EN] | flag1_q); //RULE_05
    logic edgeReset;
    // With reset enable set, the selected discharge source or the ground bit clears edge logic.
    assign edgeReset = dsch_q[B_RST_EN] & (ground //RULE_20
        | (dischargeSource[dsch_q[B_DSCH_SEL +: 3]]
           & DSCH_VALID[dsch_q[B_DSCH_SEL +: 3]])); //RULE_20
    ////////////////////////////////////////////////////////////////////
    // Synchronisers and previous levels; stage one feeds only stage two.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pinMeta_q <= 13'h0000;
            pinSync_q <= 13'h0000;
            cmpMeta_q <= 3'h0;
            cmpSync_q <= 3'h0;
            lvl1_q <= 1'b0;
            lvl2_q <= 1'b0;
        end
        else
        begin
            pinMeta_q <= externalEdgePin;
            pinSync_q <= pinMeta_q;
            cmpMeta_q <= comparatorOut;
            cmpSync_q <= cmpMeta_q;
            lvl1_q <= lvl1;
            lvl2_q <= lvl2;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Software registers.
    // Config registers take writes as they land.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= RST_REG;
            edgeSel_q <= RST_REG;
            dsch_q <= RST_REG;
        end
        else
        begin
            if (wrCtrl)
                ctrl_q <= mergeWrite(ctrl_q, wData_q, wStrb_q, MASK_CTRL);
            if (wrEdge)
                edgeSel_q <= mergeWrite(edgeSel_q, wData_q, wStrb_q, MASK_EDGE);
            if (wrDsch)
                dsch_q <= mergeWrite(dsch_q, wData_q, wStrb_q, MASK_DSCH);
        end
    end
    // Edge flags: software may write them, a hardware edge wins over a
    // software clear in the same cycle. Disable and edge reset win all.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flag1_q <= 1'b0; //RULE_22
            flag2_q <= 1'b0; //RULE_22
        end
        else if (!ctrl_q[B_UNIT_EN] || edgeReset)
        begin
            flag1_q <= 1'b0; //RULE_22
            flag2_q <= 1'b0;
        end
        else
        begin
            flag1_q <= ((wrEdge & wStrb_q[1]) ? wData_q[B_E1_FLAG]
                        : flag1_q) | ev1; //RULE_17
            flag2_q <= ((wrEdge & wStrb_q[1]) ? wData_q[B_E2_FLAG]
                        : flag2_q) | ev2; //RULE_17
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Analog control outputs, all registered.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sourceConduct <= 1'b0;
            sourceGround <= 1'b0;
            routeAdc <= 1'b0;
            routeComparator2InputB <= 1'b0;
            routeTempDiode <= 1'b0;
            currentTrim <= 6'h00;
            currentRange <= 2'h0;
            highRangeSelect <= 1'b0;
            rangeReserved <= 1'b0;
            measurePulse <= 1'b0;
            delayedPulseOut <= 1'b0;
            triggerOut <= 1'b0;
        end
        else
        begin
            // Current flows between the first and the second edge.
            sourceConduct <= unitRun & flag1_q & ~flag2_q; //RULE_21
            sourceGround <= ground; //RULE_06
            routeAdc <= unitRun & ~delayMode; //RULE_03
            routeComparator2InputB <= unitRun & delayMode; //RULE_13
            // Flags equal means no measurement owns the source.
            routeTempDiode <= unitRun & (flag1_q == flag2_q); //RULE_10
            currentTrim <= ctrl_q[B_TRIM_LO +: 6]; //RULE_08
            currentRange <= ctrl_q[B_RANGE_LO +: 2]; //RULE_09
            highRangeSelect <= edgeSel_q[B_HI_RANGE]; //RULE_19
            rangeReserved <= edgeSel_q[B_HI_RANGE] & ((ctrl_q[1:0] //RULE_19
                             & RANGE_HI_RSVD) != 2'h0);
            measurePulse <= unitRun & ~delayMode
                            & flag1_q & ~flag2_q; //RULE_15
            // Charging starts at the edge; the comparator trips later.
            delayedPulseOut <= unitRun & delayMode & flag1_q
                               & cmpSync_q[1]; //RULE_14
            // One pulse when the second edge completes a measurement.
            triggerOut <= ctrl_q[B_TRIG_EN] & ev2 & ~flag2_q; //RULE_07
        end
    end
    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            if (awTake)
                awAddr_q <= s_axi_awaddr;
            if (wTake)
            begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            // Ready drops while a half is held, so nothing is overrun.
            s_axi_awready <= ~awHeld_d;
            s_axi_wready <= ~wHeld_d;
            if (doWrite)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~rValid_d;
            s_axi_rvalid <= rValid_d;
            if (arTake)
            begin
                s_axi_rresp <= RESP_OKAY;
                unique case (s_axi_araddr)
                    OFS_CTRL: s_axi_rdata <= {16'h0000, ctrl_q};
                    OFS_EDGE: s_axi_rdata <= {16'h0000, edgeSel_q[15:10],
                        flag2_q, flag1_q, edgeSel_q[7:0]};
                    OFS_DSCH: s_axi_rdata <= {16'h0000, dsch_q};
                    // Live status of the unit.
                    OFS_STAT: s_axi_rdata <= {26'h0000000,
                        cmpSync_q[1], edgesPass, unitRun,
                        sourceConduct, flag2_q, flag1_q};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: ctm_edge_ctrl_properties.sv */
// Port-level checks for the charge-time edge control block.
// Assumes one clock domain; bound into every instance at the foot.
`timescale 1ns/1ps
`default_nettype none
module ctm_edge_ctrl_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic sourceConduct,
    input wire logic routeAdc,
    input wire logic routeComparator2InputB,
    input wire logic routeTempDiode,
    input wire logic [1:0] currentRange,
    input wire logic highRangeSelect,
    input wire logic rangeReserved,
    input wire logic measurePulse,
    input wire logic delayedPulseOut,
    input wire logic triggerOut
);
    // All checks share the one clock and the asynchronous reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////
    // Both write halves taken at one edge.
    sequence wrTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // A read address taken.
    sequence rdTake;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_write_answer: assert property (wrTake |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (rdTake |=> s_axi_rvalid)
        else $error("read data missing");
    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");

    ////////////////////////////////////////////////////////////////////
    a_route_exclusive: assert property (
        !(routeAdc && routeComparator2InputB))
        else $error("current routed twice");
    a_diode_quiet: assert property (
        routeTempDiode |-> !sourceConduct)
        else $error("diode routed while charging");
    a_trig_single: assert property (triggerOut |=> !triggerOut)
        else $error("trigger longer than one cycle");
    a_delay_routed: assert property (
        delayedPulseOut |-> routeComparator2InputB)
        else $error("delay pulse outside delay mode");
    a_time_pulse: assert property (measurePulse |-> routeAdc)
        else $error("time pulse outside time mode");
    a_range_reserved: assert property (
        rangeReserved == (highRangeSelect && currentRange[1]))
        else $error("reserved range flag wrong");
    a_reset_quiet: assert property ($rose(nrst)
        |-> !sourceConduct && !triggerOut && !measurePulse)
        else $error("source active after reset");
endmodule

bind ctm_edge_ctrl ctm_edge_ctrl_chk u_chk (.*);
`default_nettype wire

/* File: ctm_edge_partner.sv */
// Delay capacitor and comparator 2 on the far side of the source.
// Assumes the block's clock; trip point is a plain charge count.
`timescale 1ns/1ps
`default_nettype none
module ctm_edge_partner #(
    parameter int CHARGE = 6
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sourceConduct,
    input wire logic sourceGround,
    input wire logic routeComparator2InputB,
    output logic [2:0] comparatorOut
);
    int chargeLevel_q; // Charge held on the delay capacitor.

    // The capacitor only charges while the source feeds input B, and it
    // keeps its charge afterwards, so a stale trip persists until grounded.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            chargeLevel_q <= 0;
        else if (sourceGround)
            chargeLevel_q <= 0;
        else if (sourceConduct && routeComparator2InputB)
            chargeLevel_q <= chargeLevel_q + 1;
    end

    // Comparator 2 trips once the charge passes the reference.
    assign comparatorOut = {1'b0, chargeLevel_q >= CHARGE, 1'b0};
    // Software keeps the A/D request on with channel 24 set.
    // In time mode software holds the A/D sample switch closed.
endmodule
`default_nettype wire

/* File: ctm_edge_ctrl_tb.sv */
// Self-checking bench for the charge-time edge control block.
// Assumes the partner model for comparator 2 and edge pins 1 and 9.
`timescale 1ns/1ps
`default_nettype none
module ctm_edge_ctrl_tb;
    import ctm_pkg::*;
    logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, idleMode;
    logic timerMatch, outputCompareChannel, periphClkTick;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, currentRange;
    logic [12:0] externalEdgePin;
    logic [2:0] captureIrq, comparatorOut;
    logic [7:0] dischargeSource;
    logic sourceConduct, sourceGround, routeAdc, routeComparator2InputB;
    logic routeTempDiode, highRangeSelect, rangeReserved, measurePulse;
    logic delayedPulseOut, triggerOut;
    logic [5:0] currentTrim;
    int failures, n_compared, trigCount;
    int mdl [4]; // Register contents as software wrote them.
    // Control words; SEL puts edge 1 on pin 1, edge 2 on pin 9, rising.
    localparam logic [15:0] EN = 16'h8000, IDL = 16'h2000, DLY = 16'h1000;
    localparam logic [15:0] GT = 16'h0800, ORD = 16'h0400, GND = 16'h0200;
    localparam logic [15:0] TRG = 16'h0100, SEL = 16'hCCD0;

    ctm_edge_ctrl dut (.*);
    ctm_edge_partner #(.CHARGE(6)) u_far (.*);

    ////////////////////////////////////////////////////////////////////
    // Free-running 200 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Counts trigger pulses.
    always @(posedge clk)
        if (triggerOut === 1'b1)
            trigCount++;

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One AXI write; the model keeps only the writable bits.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        int n;
        logic b;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        for (n = 0; n < 30 && !b; n++)
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                b = 1'b1;
                s_axi_bready <= 1'b0;
                chk("bresp", 32'(s_axi_bresp), 32'(RESP_OKAY));
            end
        end
        mdl[a[3:2]] = d & (a == OFS_CTRL ? MASK_CTRL :
            a == OFS_EDGE ? MASK_EDGE : MASK_DSCH);
        if (!b)
        begin
            failures++;
            complete_run();
        end
    endtask

    // One AXI read, compared with the expected word.
    task automatic rdc(input logic [3:0] a, input logic [31:0] e,
        input string nm);
        int n;
        logic b;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        b = 1'b0;
        for (n = 0; n < 30 && !b; n++)
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                b = 1'b1;
                s_axi_rready <= 1'b0;
                chk(nm, s_axi_rdata, e);
            end
        end
        if (!b)
        begin
            failures++;
            complete_run();
        end
    endtask

    // Bounded wait for a level, then compare; a timeout ends the run.
    task automatic wt(ref logic s, input logic v, input string nm);
        int n;
        for (n = 0; n < 40 && s !== v; n++)
            @(posedge clk);
        chk(nm, 32'(s), 32'(v));
        if (s !== v)
            complete_run();
    endtask

    // Pin pulse that outlasts the synchroniser.
    task automatic hit(input int p);
        @(posedge clk);
        externalEdgePin[p] <= 1'b1;
        repeat (3) @(posedge clk);
        externalEdgePin[p] <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, idleMode, timerMatch} = 4'h0;
        {outputCompareChannel, periphClkTick} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        s_axi_wstrb = 4'h3;
        {externalEdgePin, captureIrq, dischargeSource} = 24'h0;
        {failures, n_compared, trigCount} = 96'h0;
        rv = $urandom(65);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++)
            rdc(4'(4 * i), 32'h0, "reset value");
        $display("test reset values done");
        // Random settings with the unit off.
        for (int i = 0; i < 6; i++)
        begin
            rv = $urandom;
            wr(OFS_CTRL, rv[15:0] & 16'h7FFF);
            wr(OFS_EDGE, rv[31:16] & 16'hFCFF);
            wr(OFS_DSCH, rv[31:16]);
            for (int r = 0; r < 3; r++)
                rdc(4'(4 * r), 32'(mdl[r]), "register");
            chk("trim", 32'(currentTrim), 32'(mdl[0][7:2]));
            chk("range", 32'(currentRange), 32'(mdl[0][1:0]));
            chk("hi range", 32'(highRangeSelect), 32'(mdl[1][0]));
            chk("rsvd", 32'(rangeReserved),
                32'(mdl[1][0] & mdl[0][1]));
        end
        $display("test random registers done");
        // Time mode with ordering and trigger: edge 2 first is ignored.
        wr(OFS_DSCH, 16'h0000);
        wr(OFS_EDGE, SEL);
        wr(OFS_CTRL, EN | GT | ORD | TRG | 16'h000A);
        hit(8);
        chk("early edge two", 32'(sourceConduct), 32'h0);
        rdc(OFS_STAT, 32'h18, "status");
        hit(0);
        wt(sourceConduct, 1'b1, "conduct on");
        chk("time pulse", 32'(measurePulse), 32'h1);
        chk("adc route", 32'(routeAdc), 32'h1);
        hit(8);
        wt(sourceConduct, 1'b0, "conduct off");
        chk("trigger", 32'(trigCount), 32'h1);
        chk("diode", 32'(routeTempDiode), 32'h1);
        rdc(OFS_STAT, 32'h1B, "status");
        $display("test ordered edges done");
        // No ordering, no trigger: edges independent, no pulse.
        wr(OFS_EDGE, SEL);
        wr(OFS_CTRL, EN | GT);
        hit(8);
        hit(0);
        chk("unordered", 32'(sourceConduct), 32'h0);
        chk("no trigger", 32'(trigCount), 32'h1);
        rdc(OFS_STAT, 32'h1B, "status");
        // Gate closed blocks edge 1.
        wr(OFS_EDGE, SEL);
        wr(OFS_CTRL, EN);
        hit(0);
        chk("gated", 32'(sourceConduct), 32'h0);
        // Idle stop halts the unit only while idle.
        wr(OFS_CTRL, EN | GT | IDL);
        idleMode <= 1'b1;
        hit(0);
        chk("idle", 32'(sourceConduct), 32'h0);
        idleMode <= 1'b0;
        hit(0);
        wt(sourceConduct, 1'b1, "after idle");
        wr(OFS_CTRL, 16'h0000);
        wt(sourceConduct, 1'b0, "disabled");
        rdc(OFS_EDGE, 32'(SEL), "flags cleared");
        $display("test gate idle disable done");
        // Grounding and a software-set flag.
        wr(OFS_CTRL, EN | GND);
        wt(sourceGround, 1'b1, "ground");
        wr(OFS_EDGE, SEL | 16'h0100);
        wt(sourceConduct, 1'b1, "soft flag");
        wr(OFS_DSCH, 16'h0010);
        wt(sourceConduct, 1'b0, "edge reset");
        // Delay mode: edge 1 starts the capacitor charging; wait for the trip.
        wr(OFS_CTRL, 16'h0000);
        wr(OFS_EDGE, SEL);
        wr(OFS_CTRL, EN | GT | DLY);
        hit(0);
        wt(routeComparator2InputB, 1'b1, "cmp route");
        wt(delayedPulseOut, 1'b1, "delay pulse");
        chk("no adc route", 32'(routeAdc), 32'h0);
        // Reset in mid-run returns everything to rest.
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        chk("reset conduct", 32'(sourceConduct), 32'h0);
        rdc(OFS_CTRL, 32'h0, "reset control");
        $display("test delay and reset done");
        complete_run();
    end
endmodule
`default_nettype wire
